// File: ars_pkg.sv
// Purpose: Shared constants and types for the converter result block
// Assumes: Byte addresses on a 32-bit Avalon-MM bus
// Notes: Offsets are full byte addresses
package ars_pkg;
  localparam int DATA_W = 11;
  localparam logic [31:0] ADDR_DIVIDER = 32'h4000_B1C0;
  localparam logic [31:0] ADDR_STATUS = 32'h4000_B1C4;
  localparam logic [31:0] ADDR_SLOT0 = 32'h4000_B1C8;
  localparam logic [31:0] ADDR_SLOT1 = 32'h4000_B1CC;
  localparam logic [31:0] ADDR_SLOT2 = 32'h4000_B1D0;
  localparam logic [31:0] ADDR_SLOT3 = 32'h4000_B1D4;
  localparam logic [31:0] ADDR_CONTROL = 32'h4000_B1D8;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h4000_B1DC;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000_B1E0;
  // Divider fields
  localparam int DIV_FRAC_LSB = 0;
  localparam int DIV_INT_LSB = 8;
  localparam int DIV_INVERT_BIT = 20;
  localparam logic [11:0] DIV_INT_RESET = 12'h01A;
  localparam logic [7:0] DIV_FRAC_RESET = 8'h00;
  localparam logic DIV_INVERT_RESET = 1'b0;
  // Status fields
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_CH_LSB = 12;
  localparam int STAT_DONE_BIT = 16;
  // Control fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SINGLE_BIT = 24;
  localparam logic [2:0] CTRL_SEL_RESET = 3'h0;
  localparam logic CTRL_SINGLE_RESET = 1'b0;
  // Interrupt bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_WRAP_BIT = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [DATA_W-1:0] RESULT_RESET = 11'h000;
  localparam logic [1:0] LAST_SLOT = 2'h3;
  localparam logic [8:0] FRAC_ONE = 9'h100;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } ars_result_s;

  typedef struct packed {
    logic clk_en;
    logic clk_invert;
    logic [2:0] input_sel;
  } ars_core_ctrl_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } ars_bus_e;

  // Merge write data into a register under byte enables
  function automatic logic [31:0] ars_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// File: ars_clk_div.sv
// Purpose: Fractional divider making the converter clock enable
// Assumes: Ratio is integer plus fraction over 256
// Notes: Ratios below one are treated as one
`timescale 1ns/1ps
`default_nettype none
module ars_clk_div import ars_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [11:0] div_int,
  input wire logic [7:0] div_frac,
  output logic tick_q
);
  logic [20:0] acc_q;
  logic [20:0] sum;
  logic [20:0] ratio;

  always_comb begin
    ratio = {1'b0, div_int, div_frac};
    if (ratio < {12'h000, FRAC_ONE}) begin
      ratio = {12'h000, FRAC_ONE};
    end
    sum = acc_q + {12'h000, FRAC_ONE};
  end

  // Accumulate and emit one pulse per ratio
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_q <= 21'h000000;
      tick_q <= 1'b0;
    end else if (acc_q >= ratio) begin
      acc_q <= 21'h000000; // Restart after the ratio is lowered
      tick_q <= 1'b0;
    end else if (sum >= ratio) begin
      acc_q <= sum - ratio;
      tick_q <= 1'b1;
    end else begin
      acc_q <= sum;
      tick_q <= 1'b0;
    end
  end
endmodule // ars_clk_div
`default_nettype wire

// File: ars_slot_seq.sv
// Purpose: Chooses the converter input and the result slot
// Assumes: One completion pulse per conversion
// Notes: Multiplex steps slots 0 to 3 in turn
`timescale 1ns/1ps
`default_nettype none
module ars_slot_seq import ars_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic single_input_control,
  input wire logic [2:0] input_select_field,
  input wire logic conv_done,
  output logic [1:0] slot,
  output logic [2:0] core_input,
  output logic wrap
);
  logic [1:0] mux_slot_q;

  // Advance the multiplex slot on each completion, except in single input mode
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mux_slot_q <= 2'h0;
    end else if (!single_input_control && conv_done) begin
      mux_slot_q <= mux_slot_q + 2'h1;
    end
  end

  always_comb begin
    if (single_input_control) begin
      slot = input_select_field[1:0];
      core_input = input_select_field;
    end else begin
      slot = mux_slot_q;
      core_input = {input_select_field[2], mux_slot_q};
    end
    wrap = conv_done && !single_input_control && (mux_slot_q == LAST_SLOT);
  end
endmodule // ars_slot_seq
`default_nettype wire

// File: ars_regs.sv
// Purpose: Divider, status and result registers of the converter
// Assumes: Avalon-MM slave, byte addresses, one wait cycle per access
// Notes: Operation
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ars_regs import ars_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire ars_result_s conv_result,
  output ars_core_ctrl_s core_ctrl,
  output logic irq
);
  ars_bus_e bus_q;
  logic [11:0] div_int_q;
  logic [7:0] div_frac_q;
  logic div_invert_q;
  logic single_q;
  logic [2:0] sel_q;
  logic done_q;
  logic [1:0] chan_q;
  logic [DATA_W-1:0] out_q;
  logic [DATA_W-1:0] slot_q [4];
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [31:0] rdata_d;
  logic [31:0] div_word;
  logic [31:0] ctrl_word;
  logic [31:0] div_merged;
  logic [31:0] ctrl_merged;
  logic req;
  logic take;
  logic wr_en;
  logic rd_en;
  logic [1:0] cur_slot;
  logic [2:0] core_input;
  logic wrap;
  logic tick;

  assign req = avs_read || avs_write;
  assign take = req && (bus_q == BUS_ACK);
  assign wr_en = take && avs_write;
  assign rd_en = take && avs_read;
  assign avs_waitrequest = req && (bus_q != BUS_ACK);

  // Bus handshake: one wait cycle, then accept
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_q <= BUS_IDLE;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (req) begin
            bus_q <= BUS_ACK;
          end
        end
        BUS_ACK: bus_q <= BUS_IDLE;
        default: bus_q <= BUS_IDLE;
      endcase
    end
  end

  assign div_word = {11'h000, div_invert_q, div_int_q, div_frac_q};
  assign ctrl_word = {7'h00, single_q, 21'h000000, sel_q};
  assign div_merged = ars_merge(div_word, avs_writedata, avs_byteenable);
  assign ctrl_merged = ars_merge(ctrl_word, avs_writedata, avs_byteenable);

  // Divider register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_int_q <= DIV_INT_RESET;
      div_frac_q <= DIV_FRAC_RESET;
      div_invert_q <= DIV_INVERT_RESET;
    end else if (wr_en && avs_address == ADDR_DIVIDER) begin
      div_int_q <= div_merged[DIV_INT_LSB +: 12];
      div_frac_q <= div_merged[DIV_FRAC_LSB +: 8];
      div_invert_q <= div_merged[DIV_INVERT_BIT];
    end
  end

  // Input selection control
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      single_q <= CTRL_SINGLE_RESET;
      sel_q <= CTRL_SEL_RESET;
    end else if (wr_en && avs_address == ADDR_CONTROL) begin
      single_q <= ctrl_merged[CTRL_SINGLE_BIT];
      sel_q <= ctrl_merged[CTRL_SEL_LSB +: 3];
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (wr_en && avs_address == ADDR_IRQ_MASK
                 && avs_byteenable[0]) begin
      irq_mask_q <= avs_writedata[IRQ_W-1:0];
    end
  end

  ars_clk_div u_div (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .div_int(div_int_q),
    .div_frac(div_frac_q),
    .tick_q(tick)
  );

  ars_slot_seq u_seq (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .single_input_control(single_q),
    .input_select_field(sel_q),
    .conv_done(conv_result.valid),
    .slot(cur_slot),
    .core_input(core_input),
    .wrap(wrap)
  );

  assign core_ctrl.clk_en = tick;
  assign core_ctrl.clk_invert = div_invert_q;
  assign core_ctrl.input_sel = core_input;

  // Status and slot capture, all in one edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      chan_q <= 2'h0;
      out_q <= RESULT_RESET;
    end else if (conv_result.valid) begin
      done_q <= 1'b1;
      chan_q <= cur_slot;
      out_q <= conv_result.data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        slot_q[i] <= RESULT_RESET;
      end
    end else if (conv_result.valid) begin
      slot_q[cur_slot] <= conv_result.data;
    end
  end

  // Sticky events; a read clears, a new event wins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_stat_q <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_DONE_BIT && conv_result.valid)
            || (i == IRQ_WRAP_BIT && wrap)) begin
          irq_stat_q[i] <= 1'b1;
        end else if (rd_en && avs_address == ADDR_IRQ_STATUS) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read mux; unmapped reads return zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (avs_address)
      ADDR_DIVIDER: rdata_d = div_word;
      ADDR_STATUS: begin
        rdata_d[STAT_DONE_BIT] = done_q;
        rdata_d[STAT_CH_LSB +: 2] = chan_q;
        rdata_d[STAT_OUT_LSB +: DATA_W] = out_q;
      end
      ADDR_SLOT0: rdata_d[DATA_W-1:0] = slot_q[0];
      ADDR_SLOT1: rdata_d[DATA_W-1:0] = slot_q[1];
      ADDR_SLOT2: rdata_d[DATA_W-1:0] = slot_q[2];
      ADDR_SLOT3: rdata_d[DATA_W-1:0] = slot_q[3];
      ADDR_CONTROL: rdata_d = ctrl_word;
      ADDR_IRQ_STATUS: rdata_d[IRQ_W-1:0] = irq_stat_q;
      ADDR_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data registered in the wait cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && bus_q == BUS_IDLE) begin
      avs_readdata <= rdata_d;
    end
  end

  // Checks
  property p_div_write;
    @(posedge clk_sys) disable iff (sys_rst)
    (wr_en && avs_address == ADDR_DIVIDER && avs_byteenable == 4'hF)
      |=> (div_int_q == $past(avs_writedata[19:8])
           && div_frac_q == $past(avs_writedata[7:0]));
  endproperty
  a_div_write: assert property (p_div_write)
    else $error("divider fields not stored");

  property p_done_set;
    @(posedge clk_sys) disable iff (sys_rst)
    conv_result.valid |=> done_q ##1 done_q;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done flag not held after a result");

  property p_chan;
    @(posedge clk_sys) disable iff (sys_rst)
    conv_result.valid |=> chan_q == $past(cur_slot);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel index not the converting slot");

  property p_out_match;
    @(posedge clk_sys) disable iff (sys_rst)
    done_q |-> slot_q[chan_q] == out_q;
  endproperty
  a_out_match: assert property (p_out_match)
    else $error("status result differs from its slot");

  property p_slot0;
    @(posedge clk_sys) disable iff (sys_rst)
    (rd_en && avs_address == ADDR_SLOT0)
      |-> avs_readdata == {21'h000000, $past(slot_q[0])};
  endproperty
  a_slot0: assert property (p_slot0)
    else $error("slot 0 read wrong");

  property p_slot_upd;
    @(posedge clk_sys) disable iff (sys_rst)
    (conv_result.valid && cur_slot == 2'h1)
      |=> slot_q[1] == $past(conv_result.data);
  endproperty
  a_slot_upd: assert property (p_slot_upd)
    else $error("slot register not updated");

  property p_mux_input;
    @(posedge clk_sys) disable iff (sys_rst)
    !single_q |-> core_ctrl.input_sel == {sel_q[2], cur_slot};
  endproperty
  a_mux_input: assert property (p_mux_input)
    else $error("multiplexed input outside selected group");

  property p_reset_zero;
    @(posedge clk_sys)
    sys_rst |=> !done_q && out_q == RESULT_RESET
                && slot_q[3] == RESULT_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("results not cleared by reset");

  property p_wait_one;
    @(posedge clk_sys) disable iff (sys_rst)
    ($rose(req) && bus_q == BUS_IDLE) |-> avs_waitrequest ##1
      !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer not after one wait cycle");

  property p_rd_status;
    @(posedge clk_sys) disable iff (sys_rst)
    (rd_en && avs_address == ADDR_STATUS)
      |-> avs_readdata == {15'h0000, $past(done_q), 2'h0, $past(chan_q),
                           1'b0, $past(out_q)};
  endproperty
  a_rd_status: assert property (p_rd_status)
    else $error("status read wrong");

  property p_done_irq;
    @(posedge clk_sys) disable iff (sys_rst)
    conv_result.valid |=> irq_stat_q[IRQ_DONE_BIT];
  endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("done event not latched");

  property p_wrap_irq;
    @(posedge clk_sys) disable iff (sys_rst)
    wrap |=> irq_stat_q[IRQ_WRAP_BIT];
  endproperty
  a_wrap_irq: assert property (p_wrap_irq)
    else $error("wrap event not latched");

  property p_irq_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    (rd_en && avs_address == ADDR_IRQ_STATUS && !conv_result.valid)
      |=> irq_stat_q == '0;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("event bits not cleared by read");

  property p_mux_step;
    @(posedge clk_sys) disable iff (sys_rst)
    (!single_q && conv_result.valid) ##1 !single_q
      |-> cur_slot == 2'($past(cur_slot) + 2'h1);
  endproperty
  a_mux_step: assert property (p_mux_step)
    else $error("multiplex slot did not advance");

  property p_single_slot;
    @(posedge clk_sys) disable iff (sys_rst)
    single_q |-> cur_slot == sel_q[1:0] && core_ctrl.input_sel == sel_q;
  endproperty
  a_single_slot: assert property (p_single_slot)
    else $error("single input slot wrong");

  property p_rdata_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  c_done: cover property (@(posedge clk_sys) disable iff (sys_rst)
    conv_result.valid ##1 done_q);
  c_wrap: cover property (@(posedge clk_sys) disable iff (sys_rst)
    wrap);
  c_irq: cover property (@(posedge clk_sys) disable iff (sys_rst)
    irq ##[1:20] !irq);
  c_single: cover property (@(posedge clk_sys) disable iff (sys_rst)
    single_q && conv_result.valid);
endmodule // ars_regs
`default_nettype wire

// File: adc_result_status_regs_bench.sv
// Purpose: Self-checking bench for the converter result registers
// Assumes: Avalon-MM accesses one at a time, results driven by the bench
// Notes: Model keeps control, status, slots, irq bits, irq mask and slot counter
`timescale 1ns/1ps
`default_nettype none
module adc_result_status_regs_bench import ars_pkg::*;;
  logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, irq;
  logic [31:0] avs_address, avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  ars_result_s conv_result;
  ars_core_ctrl_s core_ctrl;
  int err_total, n_tests;
  logic [31:0] m_ctrl, m_stat;
  logic [10:0] m_slot [4];
  logic [1:0] m_irq, m_mask, m_cnt;

  ars_regs ars_regs_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_result(conv_result), .core_ctrl(core_ctrl), .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t bit got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Hold request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 50) begin
        err_total++;
        test_done;
      end
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'h0);
    chk_reg(q, exp);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask

  // Back-to-back result pulses with random data
  task automatic conv(input int n);
    logic [10:0] d;
    logic [1:0] s;
    for (int i = 0; i < n; i++) begin
      d = 11'($urandom);
      s = m_ctrl[24] ? m_ctrl[1:0] : m_cnt;
      @(posedge clk_sys);
      conv_result <= {1'b1, d};
      m_slot[s] = d;
      m_stat = {15'h0, 1'b1, 2'h0, s, 1'b0, d};
      m_irq[IRQ_DONE_BIT] = 1'b1;
      if (!m_ctrl[24]) begin
        if (m_cnt == LAST_SLOT) m_irq[IRQ_WRAP_BIT] = 1'b1;
        m_cnt = m_cnt + 2'h1;
      end
    end
    @(posedge clk_sys);
    conv_result <= '0;
  endtask

  task automatic chk_out;
    @(negedge clk_sys);
    chk_bit(irq, |(m_irq & m_mask));
    chk_reg({29'h0, core_ctrl.input_sel}, m_ctrl[24] ?
            {29'h0, m_ctrl[2:0]} : {29'h0, m_ctrl[2], m_cnt});
  endtask

  task automatic chk_regs;
    rd(ADDR_STATUS, m_stat);
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_SLOT0 + 32'(4 * i),
         {21'h0, m_slot[i]});
    end
  endtask

  task automatic clr_irq;
    rd(ADDR_IRQ_STATUS, {30'h0, m_irq});
    m_irq = 2'h0;
  endtask

  initial begin
    int n;
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 32'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    conv_result = '0;
    err_total = 0;
    n_tests = 0;
    m_ctrl = 32'h0;
    m_stat = 32'h0;
    m_irq = 2'h0;
    m_mask = 2'h0;
    m_cnt = 2'h0;
    for (int i = 0; i < 4; i++) m_slot[i] = 11'h000;
    void'($urandom(32'h1dfd));
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // Reset values and unmapped read
    rd(ADDR_DIVIDER, 32'h0000_1A00);
    chk_regs;
    rd(ADDR_CONTROL, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h0);
    clr_irq;
    rd(32'h4000_B1F0, 32'h0);
    $display("Test reset values done");
    // Divider fields and byte lanes
    wr(ADDR_DIVIDER, 32'h0012_3456, 4'hF);
    rd(ADDR_DIVIDER, 32'h0012_3456);
    chk_bit(core_ctrl.clk_invert, 1'b1);
    wr(ADDR_DIVIDER, 32'hFFFF_FFAB, 4'h1);
    rd(ADDR_DIVIDER, 32'h0012_34AB);
    wr(ADDR_DIVIDER, 32'h0000_2100, 4'h6);
    rd(ADDR_DIVIDER, 32'h0000_21AB);
    wr(ADDR_DIVIDER, 32'h0000_0200, 4'hF);
    n = 0;
    repeat (40) begin
      @(negedge clk_sys);
      if (core_ctrl.clk_en === 1'b1) n++;
    end
    chk_bit(n >= 19 && n <= 21, 1'b1);
    $display("Test divider done");
    // Writes to read-only status and slot ignored
    wr(ADDR_STATUS, 32'hFFFF_FFFF, 4'hF);
    wr(ADDR_SLOT2, 32'hFFFF_FFFF, 4'hF);
    chk_regs;
    // Multiplex lower group, wrap past slot 3
    wr(ADDR_IRQ_MASK, 32'h3, 4'h1);
    m_mask = 2'h3;
    conv(5);
    chk_out;
    chk_regs;
    clr_irq;
    chk_out;
    $display("Test multiplex lower group done");
    // Upper group with irq masked off
    wr(ADDR_CONTROL, 32'h4, 4'hF);
    m_ctrl = 32'h4;
    wr(ADDR_IRQ_MASK, 32'h0, 4'h1);
    m_mask = 2'h0;
    conv(3);
    chk_out;
    chk_regs;
    wr(ADDR_IRQ_MASK, 32'h1, 4'h1);
    m_mask = 2'h1;
    chk_out;
    clr_irq;
    chk_out;
    $display("Test multiplex upper group done");
    // Single input mode, every select value
    for (int s = 0; s < 8; s++) begin
      m_ctrl = 32'h0100_0000 | 32'(s);
      wr(ADDR_CONTROL, m_ctrl, 4'hF);
      conv(1);
      chk_out;
      rd(ADDR_STATUS, m_stat);
    end
    chk_regs;
    $display("Test single input done");
    test_done;
  end

  initial begin
    repeat (50000) @(posedge clk_sys);
    err_total++;
    test_done;
  end
endmodule // adc_result_status_regs_bench
`default_nettype wire
